// File: design/alm_top.sv
// level monitor for one converter channel: fast detect and peak monitor
// assumes magnitude arrives on clock_in; sysref arrives asynchronously
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module alm_top
    import alm_pkg::*;
#(
    parameter int MAG_W = ALM_THR_W
) (
    // clock and reset
    input  wire logic             clock_in,
    input  wire logic             rst_n_in,
    // converter data
    input  wire logic [MAG_W-1:0] mag_in,
    input  wire logic             sysref_in,
    // register port
    input  wire logic [11:0]      addr_in,
    input  wire logic [7:0]       wdata_in,
    input  wire logic             wr_in,
    input  wire logic             rd_in,
    output logic      [7:0]       rdata_out,
    // fast detect pin
    output logic                  fast_detect_out
);
    // ****************************************
    // register storage
    // ****************************************
    logic [ALM_THR_W-1:0]    upper_r;    // upper threshold
    logic [ALM_THR_W-1:0]    lower_r;    // lower threshold
    logic [ALM_DWELL_W-1:0]  dwell_r;    // dwell target
    logic                    fd_en_r;    // fast detect enable
    logic                    sync_r;     // waiting for reference edge
    logic                    peak_en_r;  // peak detector enable
    logic [ALM_PERIOD_W-1:0] period_r;   // measurement period
    logic [2:0]              sel_r;      // result selection
    logic [ALM_RESULT_W-1:0] result_r;   // latched status
    logic [ALM_RESULT_W-1:0] peak_w;     // live peak from tracker
    logic [ALM_DWELL_W-1:0]  dcount_r;   // dwell countdown
    logic [2:0]              ref_r;      // sync chain plus edge stage
    logic                    ref_edge;
    logic                    align;
    logic                    upd;

    assign upd = wr_in && (addr_in == ALM_RESULT_CTRL)
                 && wdata_in[ALM_UPDATE_BIT];

    // ****************************************
    // reference edge detect
    // ****************************************
    // two flops before use; the third only feeds the edge compare
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ref_r <= 3'h0;
        end else begin
            ref_r <= {ref_r[1:0], sysref_in};
        end
    end
    assign ref_edge = ref_r[1] && !ref_r[2];
    // only the first edge after arming aligns; later ones are ignored
    assign align = ref_edge && sync_r; // RULE_06 RULE_08

    // ****************************************
    // register writes
    // ****************************************
    // plain storage registers
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            upper_r   <= '0;
            lower_r   <= '0;
            dwell_r   <= '0;
            fd_en_r   <= 1'b0;
            peak_en_r <= 1'b0;
            period_r  <= {16'h0000, ALM_PERIOD0_RST}; // RULE_10
            sel_r     <= ALM_SEL_PEAK; // RULE_14
        end else if (wr_in) begin
            case (addr_in)
                ALM_UPPER_LOW:   upper_r[7:0]  <= wdata_in; // RULE_02
                ALM_UPPER_HIGH:  upper_r[12:8] <= wdata_in[4:0];
                ALM_LOWER_LOW:   lower_r[7:0]  <= wdata_in; // RULE_01
                ALM_LOWER_HIGH:  lower_r[12:8] <= wdata_in[4:0];
                ALM_DWELL_LOW:   dwell_r[7:0]  <= wdata_in; // RULE_04
                ALM_DWELL_HIGH:  dwell_r[15:8] <= wdata_in;
                ALM_FD_CONTROL:  fd_en_r <= wdata_in[ALM_FD_EN_BIT];
                ALM_MON_CONTROL: peak_en_r <= wdata_in[ALM_PEAK_EN_BIT];
                ALM_PERIOD_0:    period_r[7:0]   <= wdata_in; // RULE_10
                ALM_PERIOD_1:    period_r[15:8]  <= wdata_in;
                ALM_PERIOD_2:    period_r[23:16] <= wdata_in;
                ALM_RESULT_CTRL: sel_r <= wdata_in[2:0]; // RULE_14
                default: begin
                end
            endcase
        end
    end

    // sync bit: a same-cycle write wins, so a fresh arm is never lost
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_r <= 1'b0;
        end else if (wr_in && addr_in == ALM_SYNC_CONTROL) begin
            sync_r <= wdata_in[ALM_SYNC_BIT];
        end else if (align) begin
            sync_r <= 1'b0; // RULE_07
        end
    end

    // ****************************************
    // peak tracker
    // ****************************************
    alm_peak #(
        .MAG_W (MAG_W)
    ) u_peak (
        .clock_in  (clock_in),
        .rst_n_in  (rst_n_in),
        .enable_in (peak_en_r),
        .period_in (period_r),
        .align_in  (align),
        .mag_in    (mag_in),
        .peak_out  (peak_w)
    );

    // status latch; unsupported selections latch zero
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            result_r <= '0;
        end else if (upd) begin
            result_r <= (sel_r == ALM_SEL_PEAK) ? peak_w : '0; // RULE_13
        end
    end

    // ****************************************
    // fast detect
    // ****************************************
    // set above upper; clear after an unbroken dwell below lower
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dcount_r        <= '0;
            fast_detect_out <= 1'b0;
        end else if (!fd_en_r) begin
            dcount_r        <= dwell_r; // RULE_03
            fast_detect_out <= 1'b0;
        end else if (ALM_THR_W'(mag_in) > upper_r) begin
            dcount_r        <= dwell_r; // RULE_02
            fast_detect_out <= 1'b1;
        end else if (ALM_THR_W'(mag_in) >= lower_r) begin
            dcount_r <= dwell_r; // RULE_05
        end else if (dcount_r == '0) begin
            fast_detect_out <= 1'b0; // RULE_01 RULE_04
        end else begin
            dcount_r <= dcount_r - 16'h0001;
        end
    end

    // ****************************************
    // read port
    // ****************************************
    // data one cycle after the strobe; update bit reads zero
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                ALM_UPPER_LOW:    rdata_out <= upper_r[7:0];
                ALM_UPPER_HIGH:   rdata_out <= {3'h0, upper_r[12:8]};
                ALM_LOWER_LOW:    rdata_out <= lower_r[7:0];
                ALM_LOWER_HIGH:   rdata_out <= {3'h0, lower_r[12:8]};
                ALM_DWELL_LOW:    rdata_out <= dwell_r[7:0];
                ALM_DWELL_HIGH:   rdata_out <= dwell_r[15:8];
                ALM_FD_CONTROL:   rdata_out <= {7'h00, fd_en_r};
                ALM_SYNC_CONTROL: rdata_out <= {7'h00, sync_r};
                ALM_MON_CONTROL:  rdata_out <= {6'h00, peak_en_r, 1'b0};
                ALM_PERIOD_0:     rdata_out <= period_r[7:0];
                ALM_PERIOD_1:     rdata_out <= period_r[15:8];
                ALM_PERIOD_2:     rdata_out <= period_r[23:16];
                ALM_RESULT_CTRL:  rdata_out <= {5'h00, sel_r};
                ALM_RESULT_0:     rdata_out <= result_r[7:0]; // RULE_15
                ALM_RESULT_1:     rdata_out <= result_r[15:8];
                ALM_RESULT_2:     rdata_out <= {4'h0, result_r[19:16]};
                default:          rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_fd_set_high: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        fd_en_r && ALM_THR_W'(mag_in) > upper_r |=> fast_detect_out) // RULE_02
        else $error("fast detect not set above upper threshold");
    a_fd_disabled: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !fd_en_r |=> !fast_detect_out) // RULE_03
        else $error("fast detect active while disabled");
    a_fd_hold_above: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        fd_en_r && fast_detect_out && ALM_THR_W'(mag_in) >= lower_r
        |=> fast_detect_out) // RULE_05
        else $error("fast detect cleared while above lower");
    a_fd_no_early: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $fell(fast_detect_out) && $past(fd_en_r) |-> $past(dcount_r) == '0)
        // RULE_04
        else $error("fast detect cleared before dwell ran out");
    a_fd_dwell_low: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        fd_en_r && ALM_THR_W'(mag_in) < lower_r && dcount_r == '0
        |=> !fast_detect_out) // RULE_01
        else $error("fast detect not cleared after dwell");
    a_sync_self_clr: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        sync_r && ref_edge && !(wr_in && addr_in == ALM_SYNC_CONTROL)
        |=> !sync_r) // RULE_07
        else $error("sync bit did not clear on reference edge");
    a_sync_one_edge: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        !sync_r && ref_edge && peak_en_r && u_peak.count_r > 24'h000001
        |=> u_peak.count_r == $past(u_peak.count_r) - 24'h000001) // RULE_06
        else $error("unarmed reference edge restarted the period");
    a_update_copy: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        upd && sel_r == ALM_SEL_PEAK |=> result_r == $past(peak_w)) // RULE_13
        else $error("update did not copy peak result");
    a_result_read: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        rd_in && addr_in == ALM_RESULT_2 |=> rdata_out[7:4] == 4'h0)
        // RULE_15
        else $error("result top byte upper nibble not zero");
    a_period_even: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        u_peak.count_r[0] == 1'b0 || !$past(peak_en_r) ||
        $past(u_peak.wrap) == 1'b0) // RULE_11
        else $error("reloaded period is odd");
    a_peak_off: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !peak_en_r |=> u_peak.run_r == '0) // RULE_09
        else $error("peak tracked while disabled");
    a_peak_grows: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        peak_en_r && !u_peak.wrap && mag_in > u_peak.run_r
        |=> u_peak.run_r == $past(mag_in)) // RULE_12
        else $error("peak missed larger sample");
    a_select_reset: assert property (@(posedge clock_in)
        $rose(rst_n_in) |-> sel_r == ALM_SEL_PEAK
        && period_r[7:0] == ALM_PERIOD0_RST)
        // RULE_10 RULE_14
        else $error("bad reset value");
    c_fd_rise: cover property (@(posedge clock_in) disable iff (!rst_n_in)
        $rose(fast_detect_out));
    c_fd_fall: cover property (@(posedge clock_in) disable iff (!rst_n_in)
        $fell(fast_detect_out));
    c_sync_align: cover property (@(posedge clock_in) disable iff (!rst_n_in)
        align);
    c_update: cover property (@(posedge clock_in) disable iff (!rst_n_in)
        upd && peak_w != '0);
endmodule

// File: design/alm_pkg.sv
// constants shared by the converter level monitor
// assumes one converter output clock and a plain byte register port
// Notes on behaviour
// (RULE_01) compare magnitude with 13-bit lower threshold
// (RULE_02) compare magnitude with 13-bit upper threshold
// (RULE_03) fast detect works only when enabled
// (RULE_04) 16-bit dwell count before output clears
// (RULE_05) any sample above lower reloads dwell
// (RULE_06) monitor sync uses next reference edge only
// (RULE_07) sync bit clears itself on that edge
// (RULE_08) software enables reference input before syncing
// (RULE_09) peak detector runs only when enabled
// (RULE_10) 24-bit period, low byte resets 0x80
// (RULE_11) period bit zero is ignored
// (RULE_12) peak restarts at each new period
// (RULE_13) update bit copies result, self clears
// (RULE_14) selection code 001 picks peak detector
// (RULE_15) 20-bit result over three read registers
package alm_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [11:0] ALM_UPPER_LOW     = 12'h247;
    localparam logic [11:0] ALM_UPPER_HIGH    = 12'h248;
    localparam logic [11:0] ALM_LOWER_LOW     = 12'h249;
    localparam logic [11:0] ALM_LOWER_HIGH    = 12'h24a;
    localparam logic [11:0] ALM_DWELL_LOW     = 12'h24b;
    localparam logic [11:0] ALM_DWELL_HIGH    = 12'h24c;
    localparam logic [11:0] ALM_FD_CONTROL    = 12'h245;
    localparam logic [11:0] ALM_SYNC_CONTROL  = 12'h26f;
    localparam logic [11:0] ALM_MON_CONTROL   = 12'h270;
    localparam logic [11:0] ALM_PERIOD_0      = 12'h271;
    localparam logic [11:0] ALM_PERIOD_1      = 12'h272;
    localparam logic [11:0] ALM_PERIOD_2      = 12'h273;
    localparam logic [11:0] ALM_RESULT_CTRL   = 12'h274;
    localparam logic [11:0] ALM_RESULT_0      = 12'h275;
    localparam logic [11:0] ALM_RESULT_1      = 12'h276;
    localparam logic [11:0] ALM_RESULT_2      = 12'h277;
    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int          ALM_FD_EN_BIT     = 0;
    localparam int          ALM_SYNC_BIT      = 0;
    localparam int          ALM_PEAK_EN_BIT   = 1;
    localparam int          ALM_UPDATE_BIT    = 4;
    localparam logic [7:0]  ALM_PERIOD0_RST   = 8'h80;
    localparam logic [2:0]  ALM_SEL_PEAK      = 3'h1;
    localparam int          ALM_THR_W         = 13;
    localparam int          ALM_DWELL_W       = 16;
    localparam int          ALM_PERIOD_W      = 24;
    localparam int          ALM_RESULT_W      = 20;
endpackage

// File: design/alm_peak.sv
// peak tracker over a programmed period of output clocks
// assumes magnitude and controls come from the same clock domain
`timescale 1ns/10ps
module alm_peak
    import alm_pkg::*;
#(
    parameter int MAG_W = 13
) (
    // clock and reset
    input  wire logic                    clock_in,
    input  wire logic                    rst_n_in,
    // controls
    input  wire logic                    enable_in,
    input  wire logic [ALM_PERIOD_W-1:0] period_in,
    input  wire logic                    align_in,
    input  wire logic [MAG_W-1:0]        mag_in,
    // result of the last finished period
    output logic      [ALM_RESULT_W-1:0] peak_out
);
    // ****************************************
    // period counter and running peak
    // ****************************************
    logic [ALM_PERIOD_W-1:0] count_r;   // cycles left in the period
    logic [MAG_W-1:0]        run_r;     // largest seen this period
    logic [ALM_PERIOD_W-1:0] even_per;  // bit zero dropped
    logic                    wrap;

    assign even_per = {period_in[ALM_PERIOD_W-1:1], 1'b0}; // RULE_11
    assign wrap = (count_r <= 24'h000001) | align_in;

    // count down; an alignment edge restarts the period at once
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_r <= 24'h000000;
        end else if (!enable_in) begin
            count_r <= 24'h000000; // RULE_09
        end else if (wrap) begin
            count_r <= even_per;
        end else begin
            count_r <= count_r - 24'h000001;
        end
    end

    // running maximum, restarted with the current sample at a wrap
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_r    <= '0;
            peak_out <= '0;
        end else if (!enable_in) begin
            run_r <= '0; // RULE_09
        end else if (wrap) begin
            peak_out <= ALM_RESULT_W'((mag_in > run_r) ? mag_in : run_r);
            run_r    <= mag_in; // RULE_12
        end else if (mag_in > run_r) begin
            run_r <= mag_in; // RULE_12
        end
    end

    c_peak_wrap: cover property (@(posedge clock_in) disable iff (!rst_n_in)
        enable_in && wrap && !align_in);
endmodule

// File: dv/alm_gain_model.sv
// gain control partner model watching the fast detect pin
// assumes the pin is a registered level on the same clock
`timescale 1ns/10ps
module alm_gain_model (
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    // fast detect pin from the monitor
    input  wire logic       fast_detect_in,
    // gain state
    output logic      [7:0] trips_out,
    output logic      [3:0] atten_out
);
    logic fd_q_r; // last pin level, for edge finding

    // ****************************************
    // attenuation follows each overrange event until it saturates at 4'hf
    // ****************************************
    // one step per rising edge only: a held pin must not run the gain away
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fd_q_r    <= 1'b0;
            trips_out <= 8'h00;
            atten_out <= 4'h0;
        end else begin
            fd_q_r <= fast_detect_in;
            if (fast_detect_in && !fd_q_r) begin // new overrange
                trips_out <= trips_out + 8'h01;
                if (atten_out != 4'hf) begin // saturate
                    atten_out <= atten_out + 4'h1;
                end
            end
        end
    end
endmodule

// File: dv/adc_level_monitor_test.sv
// self-checking bench for the converter level monitor
// assumes alm_top and alm_gain_model; one 50 MHz clock
`timescale 1ns/10ps
module adc_level_monitor_test;
    import alm_pkg::*;
    logic        clock_in  = 1'b0;          // output clock
    logic        rst_n_in  = 1'b0;          // async reset
    logic [12:0] mag       = 13'h0000;      // fine magnitude
    logic        sysref    = 1'b0;          // reference pin
    logic [11:0] addr      = 12'h000;       // register address
    logic [7:0]  wdata     = 8'h00;         // write data
    logic        wr        = 1'b0;          // write strobe
    logic        rd_s      = 1'b0;          // read strobe
    logic [7:0]  rdata;                     // read data
    logic        fd;                        // fast detect pin
    logic [7:0]  trips;                     // partner edge count
    logic [3:0]  atten;                     // partner gain step
    logic [23:0] mx;                        // largest period count seen
    logic [7:0]  d;                         // scratch byte
    logic [19:0] res;                       // scratch result
    int          err_total    = 0;          // mismatches
    int          total_checks = 0;          // comparisons
    // reset values of mapped registers, last entry unmapped
    logic [11:0] ra [13] = '{12'h245, 12'h247, 12'h248, 12'h249, 12'h24a,
        12'h24b, 12'h24c, 12'h26f, 12'h270, 12'h271, 12'h274, 12'h277,
        12'h300};
    logic [7:0]  rv [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h80, 8'h01, 8'h00, 8'h00};

    // ****************************************
    // clock, design and partner
    // ****************************************
    initial begin
        forever #10 clock_in = ~clock_in;
    end
    alm_top i_alm_top (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .mag_in(mag), .sysref_in(sysref), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd_s), .rdata_out(rdata),
        .fast_detect_out(fd));
    alm_gain_model i_alm_gain_model (.clock_in(clock_in),
        .rst_n_in(rst_n_in), .fast_detect_in(fd), .trips_out(trips),
        .atten_out(atten));

    // ****************************************
    // checking and bus tasks
    // ****************************************
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [23:0] got,
                       input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    task automatic wrt(input logic [11:0] a, input logic [7:0] v);
        @(posedge clock_in);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge clock_in);
        wr    <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe edge
    task automatic rdb(input logic [11:0] a, output logic [7:0] v);
        @(posedge clock_in);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clock_in);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rres(output logic [19:0] r);
        logic [7:0] b0, b1, b2;
        rdb(ALM_RESULT_0, b0);
        rdb(ALM_RESULT_1, b1);
        rdb(ALM_RESULT_2, b2);
        chk("result_top_nibble", b2[7:4], 4'h0);
        r = {b2[3:0], b1, b0};
    endtask
    // update latch lands one cycle after the write
    task automatic upd(input logic [7:0] v, input logic [19:0] exp);
        wrt(ALM_RESULT_CTRL, v);
        cyc(2);
        rres(res);
        chk("result", res, exp);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        cyc(4);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 13; i++) begin
            rdb(ra[i], d);
            chk("reset_value", d, rv[i]);
        end
        // fast detect: 13-bit thresholds, dwell 3
        wrt(ALM_UPPER_LOW, 8'h05);
        wrt(ALM_UPPER_HIGH, 8'he1);
        rdb(ALM_UPPER_HIGH, d);
        chk("upper_high", d, 8'h01);
        wrt(ALM_LOWER_LOW, 8'h02);
        wrt(ALM_LOWER_HIGH, 8'h01);
        wrt(ALM_DWELL_LOW, 8'h03);
        wrt(ALM_DWELL_HIGH, 8'h00);
        rdb(ALM_DWELL_LOW, d);
        chk("dwell_low", d, 8'h03);
        wrt(ALM_FD_CONTROL, 8'h01);
        @(posedge clock_in) mag <= 13'h0105;
        cyc(3);
        #1 chk("fd_at_upper", fd, 1'b0);
        @(posedge clock_in) mag <= 13'h0106;
        @(posedge clock_in);
        #1 chk("fd_above_upper", fd, 1'b1);
        @(posedge clock_in) mag <= 13'h0000;
        repeat (2) begin
            @(posedge clock_in);
            #1 chk("fd_dwell", fd, 1'b1);
        end
        // a sample at the lower threshold restarts the dwell
        @(posedge clock_in) mag <= 13'h0102;
        @(posedge clock_in) mag <= 13'h0000;
        for (int k = 1; k <= 4; k++) begin
            @(posedge clock_in);
            #1 chk("fd_reload", fd, k < 4);
        end
        @(posedge clock_in) mag <= 13'h0106;
        cyc(2);
        #1 chk("fd_set_again", fd, 1'b1);
        wrt(ALM_FD_CONTROL, 8'h00);
        mag <= 13'h1234;
        cyc(2);
        #1 chk("fd_disabled", fd, 1'b0);
        chk("partner_trips", trips, 8'h02);
        chk("partner_atten", atten, 4'h2);
        // monitor: disabled peak gives nothing
        cyc(20);
        upd(8'h11, 20'h00000);
        wrt(ALM_PERIOD_0, 8'h41);
        wrt(ALM_MON_CONTROL, 8'h03);
        rdb(ALM_MON_CONTROL, d);
        chk("mon_control", d, 8'h02);
        // an odd period of 0x41 must count as 0x40
        mx = 24'h000000;
        repeat (140) begin
            @(posedge clock_in);
            #1;
            if (i_alm_top.u_peak.count_r > mx) begin
                mx = i_alm_top.u_peak.count_r;
            end
        end
        chk("period_even", mx, 24'h000040);
        upd(8'h12, 20'h01234);
        rdb(ALM_RESULT_CTRL, d);
        chk("update_self_clear", d, 8'h02);
        upd(8'h12, 20'h00000);
        wrt(ALM_RESULT_CTRL, 8'h01);
        mag <= 13'h0010;
        cyc(140);
        upd(8'h11, 20'h00010);
        wrt(ALM_RESULT_0, 8'hff);
        rdb(ALM_RESULT_0, d);
        chk("result_read_only", d, 8'h10);
        // sync arms, then clears on the first reference edge
        wrt(ALM_SYNC_CONTROL, 8'h01);
        rdb(ALM_SYNC_CONTROL, d);
        chk("sync_armed", d, 8'h01);
        @(posedge clock_in) sysref <= 1'b1;
        cyc(4);
        sysref <= 1'b0;
        d = 8'hff;
        for (int t = 0; t < 10 && d !== 8'h00; t++) begin
            rdb(ALM_SYNC_CONTROL, d);
        end
        chk("sync_cleared", d, 8'h00);
        // a later edge without re-arming must be ignored
        @(posedge clock_in) sysref <= 1'b1;
        cyc(4);
        sysref <= 1'b0;
        rdb(ALM_SYNC_CONTROL, d);
        chk("sync_ignored", d, 8'h00);
        upd(8'h11, 20'h00010);
        test_done();
    end
endmodule
